// File: rtl/fbp_top.sv
// Purpose: per-block flash protection registers and access checking
// Assumes: AXI4-Lite slave, single clock, load of protection bytes at reset
// Notes: flash byte reads go through a simple request/valid port
//
// How it works
// - after reset each block's protection register is loaded from flash.
// - all protection registers share one address, selected by bank select.
// - block 3..0 bytes come from FF0A, FF0B, FF0C, FF0D.
// - in normal mode software writes may only clear protection bits.
// - setting protection bits is allowed only in special mode.
// - lower area starts 32k below block top, grows upward.
// - upper area ends at block top, grows downward.
// - lower and upper areas never meet for any size.
// - program or erase in protected area is refused and sets violation flag.
// - mass erase proceeds only when block protection is fully disabled.
// - bit7 open, bit6 spare, bit5 high disable, 4:3 high size, 2 low disable, 1:0 low size.
// - an erased byte FF leaves the block unprotected.
// - open flag zero protects the whole block from program and erase; mass erase still checks both disable bits.
// - a disable bit of one turns that area off, zero turns it on.
// - high size 00..11 gives 2k, 4k, 8k, 16k bytes.
// - low size 00..11 gives 512, 1k, 2k, 4k bytes.
// - fully unprotected means open flag one, or both disable bits one.
`timescale 1ns/100ps
`default_nettype none
module fbp_top
    import fbp_pkg::*;
#(
    parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        special_mode,
    // flash byte read port for the reset load
    output logic             nvm_rd_req,
    output logic [15:0]      nvm_rd_addr,
    input  wire logic        nvm_rd_valid,
    input  wire logic [7:0]  nvm_rd_data,
    // program / erase request from the command logic
    input  wire logic        op_req,
    input  wire logic [1:0]  op_kind,
    input  wire logic [1:0]  op_block,
    input  wire logic [15:0] op_addr,
    output logic             op_done,
    output logic             op_granted,
    output logic             ready,
    output logic             irq,
    // AXI4-Lite
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [1:0] {FBP_LOAD_REQ, FBP_LOAD_WAIT, FBP_RUN} fbp_state_type;

    logic [7:0]          prot_q [NUM_BLOCKS];
    logic [7:0]          prot_d [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0] viol_q, viol_d;
    logic [1:0]          bank_q, bank_d;
    logic [1:0]          ld_idx_q, ld_idx_d;
    fbp_state_type       st_q, st_d;
    logic                rd_req_q, rd_req_d;
    logic                done_q, done_d, grant_q, grant_d;
    logic [1:0]          irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
    logic                irq_q, irq_d;
    logic                ready_q, ready_d;
    logic                awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
    logic [15:0]         nvm_addr_q, nvm_addr_d;
    logic                aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]          awa_q, awa_d;
    logic [31:0]         wd_q, wd_d, rd_q, rd_d;
    logic [3:0]          ws_q, ws_d;
    logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;

    // protection decode of the block targeted by an operation
    logic [7:0]  sel_prot;
    logic [15:0] up_len, lo_len, lo_end;
    logic        in_upper, in_lower, hit, fully_open;
    always_comb begin
        sel_prot   = prot_q[op_block];
        up_len     = UPPER_MIN_LEN << sel_prot[HSIZE_LSB +: 2];
        lo_len     = LOWER_MIN_LEN << sel_prot[LSIZE_LSB +: 2];
        lo_end     = LOWER_BASE + lo_len;
        // largest lower end 0x9000 stays below smallest upper start 0xC000
        in_upper   = !sel_prot[HDIS_BIT] && (op_addr > BLOCK_TOP - up_len);
        in_lower   = !sel_prot[LDIS_BIT] && (op_addr >= LOWER_BASE)
                     && (op_addr < lo_end);
        // spare bit deliberately unused here
        fully_open = sel_prot[OPEN_BIT]
                     || (sel_prot[HDIS_BIT] && sel_prot[LDIS_BIT]);
        if (!sel_prot[OPEN_BIT]) begin
            hit = 1'b1;
        end else begin
            hit = in_upper || in_lower;
        end
    end

    logic wr_go, wr_prot, wr_ok;
    always_comb begin
        wr_go   = aw_q && w_q && !bv_q;
        wr_prot = wr_go && awa_q == PROT_OFFSET && ws_q[0];
        wr_ok   = wr_go && (awa_q == CONFIG_OFFSET || awa_q == PROT_OFFSET
                  || awa_q == STATUS_OFFSET || awa_q == IRQ_CLR_OFFSET
                  || awa_q == IRQ_EN_OFFSET);
    end

    // load sequence and protection registers
    always_comb begin
        st_d     = st_q;
        ld_idx_d = ld_idx_q;
        rd_req_d = 1'b0;
        prot_d   = prot_q;
        unique case (st_q)
            FBP_LOAD_REQ: begin
                rd_req_d = 1'b1;
                st_d     = FBP_LOAD_WAIT;
            end
            FBP_LOAD_WAIT: begin
                rd_req_d = !nvm_rd_valid;
                if (nvm_rd_valid) begin
                    prot_d[ld_idx_q] = nvm_rd_data;
                    if (ld_idx_q == 2'(NUM_BLOCKS - 1)) begin
                        st_d = FBP_RUN;
                    end else begin
                        ld_idx_d = ld_idx_q + 2'd1;
                        st_d     = FBP_LOAD_REQ;
                    end
                end
            end
            FBP_RUN: begin
                if (wr_prot) begin
                    if (special_mode) begin
                        prot_d[bank_q] = wd_q[7:0];
                    end else begin
                        prot_d[bank_q] = prot_q[bank_q] & wd_q[7:0];
                    end
                end
            end
        endcase
        ready_d    = st_d == FBP_RUN;
        // block 0 at FF0D, each higher block one byte lower
        nvm_addr_d = PROT_BYTE_BLK0 - {14'd0, ld_idx_d};
    end

    // operation check, violation flags and interrupt status
    logic op_take, op_viol;
    always_comb begin
        op_take   = op_req && st_q == FBP_RUN;
        op_viol   = op_take && ((op_kind == 2'(FBP_OP_MASS)) ? !fully_open : hit);
        done_d    = op_take;
        grant_d   = op_take && !op_viol;
        viol_d    = viol_q;
        bank_d    = bank_q;
        irq_en_d  = irq_en_q;
        irq_stat_d = irq_stat_q;
        if (wr_go && ws_q[0]) begin
            if (awa_q == CONFIG_OFFSET) bank_d = wd_q[1:0];
            if (awa_q == STATUS_OFFSET && wd_q[VIOL_BIT]) viol_d[bank_q] = 1'b0;
            if (awa_q == IRQ_CLR_OFFSET) irq_stat_d = irq_stat_q & ~wd_q[1:0];
            if (awa_q == IRQ_EN_OFFSET) irq_en_d = wd_q[1:0];
        end
        // a new event wins over a clear in the same cycle
        if (op_viol) begin
            viol_d[op_block]     = 1'b1;
            irq_stat_d[VIOL_BIT] = 1'b1;
        end
        if (op_take) irq_stat_d[DONE_BIT] = 1'b1;
        irq_d = |(irq_stat_d & irq_en_d);
    end

    // AXI4-Lite slave
    always_comb begin
        aw_d    = aw_q;
        w_d     = w_q;
        bv_d    = bv_q;
        rv_d    = rv_q;
        awa_d   = awa_q;
        wd_d    = wd_q;
        ws_d    = ws_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rd_d    = rd_q;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            bresp_d = wr_ok ? 2'b00 : 2'b10;
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rresp_d = 2'b00;
            rd_d = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                CONFIG_OFFSET:   rd_d[1:0] = bank_q;
                PROT_OFFSET:     rd_d[7:0] = prot_q[bank_q];
                STATUS_OFFSET:   rd_d[VIOL_BIT] = viol_q[bank_q];
                IRQ_STAT_OFFSET: rd_d[1:0] = irq_stat_q;
                IRQ_EN_OFFSET:   rd_d[1:0] = irq_en_q;
                IRQ_CLR_OFFSET:  rd_d = 32'h0000_0000;
                default:         rresp_d = 2'b10;
            endcase
        end
        if (rv_q && s_axi_rready) rv_d = 1'b0;
        // ready flags are registered copies so no output comes from a gate
        awrdy_d = !aw_d;
        wrdy_d  = !w_d;
        arrdy_d = !rv_d;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_q       <= FBP_LOAD_REQ;
            ld_idx_q   <= 2'd0;
            rd_req_q   <= 1'b0;
            for (int i = 0; i < NUM_BLOCKS; i++) prot_q[i] <= PROT_ERASED;
            viol_q     <= '0;
            bank_q     <= 2'd0;
            done_q     <= 1'b0;
            grant_q    <= 1'b0;
            irq_stat_q <= 2'd0;
            irq_en_q   <= 2'd0;
            irq_q      <= 1'b0;
            ready_q    <= 1'b0;
            nvm_addr_q <= PROT_BYTE_BLK0;
            aw_q       <= 1'b0;
            w_q        <= 1'b0;
            bv_q       <= 1'b0;
            rv_q       <= 1'b0;
            awrdy_q    <= 1'b1;
            wrdy_q     <= 1'b1;
            arrdy_q    <= 1'b1;
            awa_q      <= 8'h00;
            wd_q       <= 32'h0000_0000;
            ws_q       <= 4'h0;
            bresp_q    <= 2'b00;
            rresp_q    <= 2'b00;
            rd_q       <= 32'h0000_0000;
        end else begin
            st_q       <= st_d;
            ld_idx_q   <= ld_idx_d;
            rd_req_q   <= rd_req_d;
            prot_q     <= prot_d;
            viol_q     <= viol_d;
            bank_q     <= bank_d;
            done_q     <= done_d;
            grant_q    <= grant_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q   <= irq_en_d;
            irq_q      <= irq_d;
            ready_q    <= ready_d;
            nvm_addr_q <= nvm_addr_d;
            aw_q       <= aw_d;
            w_q        <= w_d;
            bv_q       <= bv_d;
            rv_q       <= rv_d;
            awrdy_q    <= awrdy_d;
            wrdy_q     <= wrdy_d;
            arrdy_q    <= arrdy_d;
            awa_q      <= awa_d;
            wd_q       <= wd_d;
            ws_q       <= ws_d;
            bresp_q    <= bresp_d;
            rresp_q    <= rresp_d;
            rd_q       <= rd_d;
        end
    end

    assign nvm_rd_req    = rd_req_q;
    assign nvm_rd_addr   = nvm_addr_q;
    assign op_done       = done_q;
    assign op_granted    = grant_q;
    assign ready         = ready_q;
    assign irq           = irq_q;
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready  = wrdy_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rresp_q;
endmodule
`default_nettype wire

// File: rtl/fbp_pkg.sv
// Purpose: constants for the flash block protection unit
// Assumes: 64k byte blocks, four blocks, byte-wide protection registers
// Notes: register offsets are word aligned on an AXI4-Lite bus
package fbp_pkg;
    localparam int unsigned NUM_BLOCKS_DEF = 4;
    // byte addresses on the register bus
    localparam logic [7:0] CONFIG_OFFSET   = 8'h00;
    localparam logic [7:0] PROT_OFFSET     = 8'h04;
    localparam logic [7:0] STATUS_OFFSET   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_CLR_OFFSET  = 8'h10;
    localparam logic [7:0] IRQ_EN_OFFSET   = 8'h14;
    // protection byte locations in flash, block 0 highest
    localparam logic [15:0] PROT_BYTE_BLK0 = 16'hFF0D;
    // protection register fields
    localparam int unsigned OPEN_BIT   = 7;
    localparam int unsigned SPARE_BIT  = 6;
    localparam int unsigned HDIS_BIT   = 5;
    localparam int unsigned HSIZE_LSB  = 3;
    localparam int unsigned LDIS_BIT   = 2;
    localparam int unsigned LSIZE_LSB  = 0;
    localparam logic [7:0] PROT_ERASED = 8'hFF;
    // geometry of a 64k byte block (block offsets)
    localparam logic [15:0] BLOCK_TOP     = 16'hFFFF;
    localparam logic [15:0] LOWER_BASE    = 16'h8000;
    localparam logic [15:0] UPPER_MIN_LEN = 16'h0800;
    localparam logic [15:0] LOWER_MIN_LEN = 16'h0200;
    // status bits
    localparam int unsigned VIOL_BIT = 0;
    localparam int unsigned DONE_BIT = 1;
    // flash operations
    typedef enum logic [1:0] {
        FBP_OP_PROGRAM,
        FBP_OP_ERASE,
        FBP_OP_MASS
    } fbp_op_type;
endpackage

// File: sim/fbp_top_properties.sv
// Purpose: port timing checks on fbp_top
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every fbp_top instance
`timescale 1ns/100ps
`default_nettype none
module fbp_top_properties (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        op_req,
    input wire logic        ready,
    input wire logic        op_done,
    input wire logic        op_granted,
    input wire logic        nvm_rd_req,
    input wire logic        nvm_rd_valid,
    input wire logic [15:0] nvm_rd_addr,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_arready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_OP_ANSWER: assert property (op_req && ready |=> op_done)
        else $error("op request not answered");
    AST_OP_QUIET: assert property (!(op_req && ready) |=> !op_done)
        else $error("op_done without request");
    AST_GRANT_DONE: assert property (op_granted |-> op_done)
        else $error("grant outside op_done");
    AST_LOAD_HOLD: assert property (nvm_rd_req && !nvm_rd_valid |=> nvm_rd_req)
        else $error("byte request dropped early");
    AST_LOAD_ADDR: assert property (nvm_rd_req && !nvm_rd_valid |=> $stable(nvm_rd_addr))
        else $error("byte address moved while pending");
    AST_READY_KEEP: assert property (ready |=> ready)
        else $error("ready fell after load");
    AST_WR_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_RD_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
endmodule
bind fbp_top fbp_top_properties i_props (.clock, .rst_b, .op_req, .ready, .op_done,
    .op_granted, .nvm_rd_req, .nvm_rd_valid, .nvm_rd_addr, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_arready);
`default_nettype wire

// File: sim/tb_fbp_top.sv
// Purpose: self-checking bench for fbp_top
// Assumes: package offsets, one clock
// Notes: bench model keeps protection bytes and violation flags
`timescale 1ns/100ps
`default_nettype none
module tb_fbp_top;
    import fbp_pkg::*;
    logic        clock, rst_b, special_mode, nvm_rd_req, nvm_rd_valid, op_req, op_done;
    logic        op_granted, ready, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [15:0] nvm_rd_addr, op_addr;
    logic [7:0]  nvm_rd_data, s_axi_awaddr, s_axi_araddr;
    logic [1:0]  op_kind, op_block, s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
    logic [3:0]  s_axi_wstrb, viol;
    logic [7:0]  prot [4];
    int          err_count, cmp_count;
    fbp_top i_dut (.*);
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic grant(logic [7:0] p, int k, logic [15:0] a);
        logic up, lo;
        up = !p[5] && a > 16'hFFFF - (16'h0800 << p[4:3]);
        lo = !p[2] && a >= 16'h8000 && a < 16'h8000 + (16'h0200 << p[1:0]);
        if (k == 2) return p[7] || (p[5] && p[2]);
        if (!p[7]) return 1'b0;
        return !(up || lo);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic op(input int k, b, input logic [15:0] a);
        @(posedge clock);
        op_req <= 1;
        op_kind <= k[1:0];
        op_block <= b[1:0];
        op_addr <= a;
        @(posedge clock);
        op_req <= 0;
        #1 chk(op_done, 1, "op_done");
        chk(op_granted, grant(prot[b], k, a), "op_granted");
        if (!grant(prot[b], k, a)) viol[b] = 1;
    endtask
    task automatic run_ops;
        logic [15:0] al [7];
        logic [7:0]  p;
        for (int b = 0; b < 4; b++) begin
            p = prot[b];
            al = '{16'h7FFF, 16'h8000, 16'h8000 + (16'h0200 << p[1:0]) - 1,
                   16'h8000 + (16'h0200 << p[1:0]), 16'hFFFF - (16'h0800 << p[4:3]),
                   16'hFFFF - (16'h0800 << p[4:3]) + 1, 16'($urandom)};
            for (int k = 0; k < 3; k++) foreach (al[i]) op(k, b, al[i]);
        end
    endtask
    task automatic check_regs;
        for (int b = 0; b < 4; b++) begin
            wr(CONFIG_OFFSET, b);
            rd(PROT_OFFSET);
            chk(d[7:0], prot[b], "prot");
            rd(STATUS_OFFSET);
            chk(d[VIOL_BIT], viol[b], "viol");
        end
        chk(irq, |viol, "irq");
    endtask
    initial begin
        #200000;
        err_count++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hF0BA113D));
        {rst_b, special_mode, nvm_rd_valid, nvm_rd_data, op_req, op_kind, op_block} = '0;
        {op_addr, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        viol = '0;
        prot = '{8'hFF, 8'($urandom) | 8'h80, 8'h7F, 8'hD8};
        repeat (16) @(posedge clock);
        rst_b <= 1;
        for (int b = 0; b < 4; b++) begin
            do @(posedge clock); while (!nvm_rd_req);
            chk(nvm_rd_addr, 16'hFF0D - b, "nvm_rd_addr");
            repeat ($urandom % 3) @(posedge clock);
            nvm_rd_valid <= 1;
            nvm_rd_data <= prot[b];
            @(posedge clock);
            nvm_rd_valid <= 0;
        end
        while (!ready) @(posedge clock);
        wr(IRQ_EN_OFFSET, 1);
        check_regs;
        run_ops;
        check_regs;
        rd(8'h40);
        chk(r, 2'b10, "unmapped resp");
        wr(8'h40, 32'h0000_0000);
        chk(r, 2'b10, "unmapped bresp");
        for (int m = 0; m < 2; m++) begin
            special_mode <= m[0];
            for (int b = 0; b < 4; b++) begin
                w = $urandom;
                wr(CONFIG_OFFSET, b);
                wr(PROT_OFFSET, w);
                prot[b] = m ? w[7:0] : prot[b] & w[7:0];
            end
            check_regs;
            run_ops;
            check_regs;
        end
        for (int b = 0; b < 4; b++) begin
            wr(CONFIG_OFFSET, b);
            wr(STATUS_OFFSET, 1);
            chk(r, 2'b00, "status bresp");
        end
        rd(IRQ_STAT_OFFSET);
        chk(d[1:0], {1'b1, |viol}, "irq_stat");
        viol = '0;
        wr(IRQ_CLR_OFFSET, 3);
        repeat (2) @(posedge clock);
        check_regs;
        rd(IRQ_STAT_OFFSET);
        chk(d[1:0], 2'b00, "irq_stat cleared");
        end_of_test;
    end
endmodule
`default_nettype wire
